// ===== pi2c_host_model.sv
`timescale 1ns/1ps
module pi2c_host_model (
  // core clock paces the bus
  input  wire logic clk_i,
  // wire level of data
  input  wire logic sda_i,
  // bus drive, 1 releases data
  output logic      scl_o,
  output logic      sda_o
);
  // idle bus: clock stands high, data released to pull-up
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic hw(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // 400 ns bit, data moves mid-low, sampled mid-high
  task automatic bitx(input logic b, output logic r);
    scl_o = 1'b0;
    hw(2);
    sda_o = b;
    hw(2);
    scl_o = 1'b1;
    hw(2);
    r = sda_i;
    hw(2);
  endtask
  // also serves as repeated start
  task automatic start();
    scl_o = 1'b0;
    hw(2);
    sda_o = 1'b1;
    hw(2);
    scl_o = 1'b1;
    hw(4);
    sda_o = 1'b0;
    hw(4);
  endtask
  task automatic stop();
    scl_o = 1'b0;
    hw(2);
    sda_o = 1'b0;
    hw(2);
    scl_o = 1'b1;
    hw(4);
    sda_o = 1'b1;
    hw(4);
  endtask
  // msb first, then the ack slot
  task automatic xbyte(input logic [7:0] d, input logic a,
                       output logic [7:0] q, output logic ak);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(a, ak);
  endtask
endmodule

// ===== pi2c_pkg.sv
package pi2c_pkg;

  // in-page register offsets, page 0 unless noted
  localparam logic [6:0] OFF_PAGE  = 7'h00; // present in every page
  localparam logic [6:0] OFF_SWRST = 7'h01;
  localparam logic [6:0] OFF_BCAST = 7'h02;
  localparam logic [6:0] OFF_CKSUM = 7'h03;

  // page numbers
  localparam logic [7:0] PAGE_MAIN   = 8'h00;
  localparam logic [7:0] PAGE_COEF_A = 8'h02;
  localparam logic [7:0] PAGE_COEF_B = 8'h03;
  localparam logic [7:0] PAGE_RESET  = 8'h00;

  // storage slots: page 0, page 2, page 3
  localparam int unsigned NUM_SLOTS = 3;
  localparam logic [1:0] SLOT_MAIN   = 2'h0;
  localparam logic [1:0] SLOT_COEF_A = 2'h1;
  localparam logic [1:0] SLOT_COEF_B = 2'h2;
  localparam int unsigned REGS_PER_PAGE = 128;

  // addressing, write form of the local address is base | straps << 1
  localparam logic [7:0] ADDR_LOCAL_BASE = 8'h90;
  localparam logic [6:0] ADDR_GLOBAL     = 7'h40;

  // field positions and resets
  localparam int unsigned BIT_SWRST   = 0;
  localparam int unsigned BIT_BCAST   = 0;
  localparam logic [7:0]  CKSUM_RESET = 8'h00;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'b0000,
    ST_ADDR     = 4'b0001,
    ST_ADDR_ACK = 4'b0010,
    ST_OFFS     = 4'b0011,
    ST_OFFS_ACK = 4'b0100,
    ST_WDATA    = 4'b0101,
    ST_WACK     = 4'b0110,
    ST_RDATA    = 4'b0111,
    ST_RACK     = 4'b1000
  } pi2c_state_e;

  typedef logic [REGS_PER_PAGE-1:0][7:0] pi2c_page_t;

  // whole state of the target, registered as one word
  typedef struct packed {
    logic [1:0]                  scl_s;     // synchroniser, [0] first
    logic [1:0]                  sda_s;
    logic [1:0]                  sdz_s;
    logic [1:0]                  strap_s0;  // {high, low} first stage
    logic [1:0]                  strap_s1;
    logic                        scl_d;
    logic                        sda_d;
    logic                        sdz_d;
    pi2c_state_e                 st;
    logic [3:0]                  cnt;
    logic [7:0]                  sh;
    logic [7:0]                  tx;
    logic                        rw;
    logic                        nack;
    logic [6:0]                  off;
    logic                        sda_oe;
    logic                        sda_lvl;
    logic [7:0]                  page;
    logic                        bcast_dis; // zero means enabled
    logic [7:0]                  cksum;
    logic [6:0]                  local_addr;
    logic [NUM_SLOTS-1:0][REGS_PER_PAGE-1:0][7:0] mem;
  } pi2c_state_s;

endpackage

// ===== pi2c_target.sv
`timescale 1ns/1ps
// Functional notes
// R01: byte-wide registers reached through page scheme
// R02: 128 registers per page, offset 0..127
// R03: page 0 selected after power-up, soft reset
// R04: page select at offset 0 of every page
// R05: coefficient storage lives in pages 2, 3
// R06: target only; oversampled up to fast-mode-plus
// R07: address byte is seven bits plus direction
// R08: straps latched on shutdown release, soft reset
// R09: straps map to 0x90, 0x92, 0x94, 0x96
// R10: global address 0x40 answered while enabled
// R11: global enable bit, reset value enabled
// R12: host ignores acknowledge on broadcast writes
// R13: readable running checksum of written data
// R14: offset auto-increments on reads and writes
// R15: write: address, offset, data, all acked
// R16: read: offset write, restart, read, nack
// R17: unmatched address: stay released, ignore transfer
// R18: new page applies after its byte acked
module pi2c_target
  import pi2c_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // device pins
  input  wire logic       shutdown_n_pin_i,
  input  wire logic       addr_strap_low_i,
  input  wire logic       addr_strap_high_i,
  // i2c bus
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  // status
  output logic [7:0]      cur_page_o,
  output logic [6:0]      local_addr_o
);

  pi2c_state_s s_reg;
  pi2c_state_s s_next;

  // strap pair to 7-bit local address
  function automatic logic [6:0] strap_addr(input logic [1:0] st);
    logic [7:0] w;
    w = ADDR_LOCAL_BASE | {5'h00, st, 1'b0}; // R09
    return w[7:1];
  endfunction

  // page number to storage slot, bit 2 flags a backed page
  function automatic logic [2:0] page_slot(input logic [7:0] pg);
    logic [2:0] r;
    r = 3'h0;
    if (pg == PAGE_MAIN)
      r = {1'b1, SLOT_MAIN};
    else if (pg == PAGE_COEF_A)
      r = {1'b1, SLOT_COEF_A}; // R05
    else if (pg == PAGE_COEF_B)
      r = {1'b1, SLOT_COEF_B}; // R05
    return r;
  endfunction

  // register read as seen by the bus
  function automatic logic [7:0] reg_read(input pi2c_state_s s,
                                          input logic [6:0] off);
    logic [2:0] sl;
    logic [7:0] r;
    sl = page_slot(s.page);
    r  = 8'h00;
    if (off == OFF_PAGE)
      r = s.page; // R04
    else if (s.page == PAGE_MAIN && off == OFF_SWRST)
      r = 8'h00;
    else if (s.page == PAGE_MAIN && off == OFF_BCAST)
      r = {7'h00, ~s.bcast_dis};
    else if (s.page == PAGE_MAIN && off == OFF_CKSUM)
      r = s.cksum; // R13
    else if (sl[2])
      r = s.mem[sl[1:0]][off]; // R01
    return r;
  endfunction

  // register defaults, shared by shutdown and soft reset
  function automatic pi2c_state_s reg_defaults(input pi2c_state_s s);
    pi2c_state_s r;
    r           = s;
    r.page      = PAGE_RESET; // R03
    r.bcast_dis = 1'b0;       // R11
    r.cksum     = CKSUM_RESET;
    r.mem       = '0;
    return r;
  endfunction

  // address byte decode
  function automatic logic addr_hit(input pi2c_state_s s,
                                    input logic [7:0] b);
    logic hit;
    hit = (b[7:1] == s.local_addr); // R07
    // reads on the shared address would collide, so writes only
    if (!s.bcast_dis && b[7:1] == ADDR_GLOBAL && !b[0])
      hit = 1'b1; // R10
    return hit;
  endfunction

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic sdz_rise;

  // edges seen only on second-stage and delayed copies
  always_comb begin
    scl_rise  = s_reg.scl_s[1] & ~s_reg.scl_d;
    scl_fall  = ~s_reg.scl_s[1] & s_reg.scl_d;
    bus_start = s_reg.scl_s[1] & s_reg.scl_d & s_reg.sda_d & ~s_reg.sda_s[1];
    bus_stop  = s_reg.scl_s[1] & s_reg.scl_d & ~s_reg.sda_d & s_reg.sda_s[1];
    sdz_rise  = s_reg.sdz_s[1] & ~s_reg.sdz_d;
  end

  // next-state logic of the whole target
  always_comb begin
    logic [2:0] sl;
    logic [7:0] rd;
    s_next          = s_reg;
    sl              = page_slot(s_reg.page);
    rd              = reg_read(s_reg, s_reg.off);
    s_next.scl_s    = {s_reg.scl_s[0], scl_i}; // R06
    s_next.sda_s    = {s_reg.sda_s[0], sda_i};
    s_next.sdz_s    = {s_reg.sdz_s[0], shutdown_n_pin_i};
    s_next.strap_s0 = {addr_strap_high_i, addr_strap_low_i};
    s_next.strap_s1 = s_reg.strap_s0;
    s_next.scl_d    = s_reg.scl_s[1];
    s_next.sda_d    = s_reg.sda_s[1];
    s_next.sdz_d    = s_reg.sdz_s[1];
    s_next.sda_lvl  = 1'b0; // open drain, only ever pulls low
    if (!s_reg.sdz_s[1]) begin
      // shutdown holds registers at default and the bus released
      s_next        = reg_defaults(s_next);
      s_next.st     = ST_IDLE;
      s_next.sda_oe = 1'b0;
      s_next.off    = 7'h00;
    end else begin
      if (sdz_rise)
        s_next.local_addr = strap_addr(s_reg.strap_s1); // R08
      if (bus_start) begin
        s_next.st     = ST_ADDR;
        s_next.cnt    = 4'h0;
        s_next.sda_oe = 1'b0;
      end else if (bus_stop) begin
        s_next.st     = ST_IDLE;
        s_next.sda_oe = 1'b0;
      end else begin
        unique case (s_reg.st)
          ST_IDLE: begin
            s_next.sda_oe = 1'b0; // R17
          end
          ST_ADDR, ST_OFFS, ST_WDATA: begin
            if (scl_rise) begin
              s_next.sh  = {s_reg.sh[6:0], s_reg.sda_s[1]};
              s_next.cnt = s_reg.cnt + 4'h1;
            end else if (scl_fall && s_reg.cnt == BITS_PER_BYTE) begin
              s_next.cnt    = 4'h0;
              s_next.sda_oe = 1'b1; // R15
              if (s_reg.st == ST_ADDR) begin
                if (addr_hit(s_reg, s_reg.sh)) begin
                  s_next.rw = s_reg.sh[0];
                  s_next.st = ST_ADDR_ACK;
                end else begin
                  s_next.sda_oe = 1'b0; // R17
                  s_next.st     = ST_IDLE;
                end
              end else if (s_reg.st == ST_OFFS) begin
                s_next.off = s_reg.sh[6:0]; // R02
                s_next.st  = ST_OFFS_ACK;
              end else begin
                s_next.st = ST_WACK;
              end
            end
          end
          ST_ADDR_ACK: begin
            if (scl_fall) begin
              s_next.cnt = 4'h0;
              if (s_reg.rw) begin
                s_next.tx     = rd;
                s_next.sda_oe = ~rd[7]; // R16
                s_next.off    = s_reg.off + 7'h01; // R14
                s_next.st     = ST_RDATA;
              end else begin
                s_next.sda_oe = 1'b0;
                s_next.st     = ST_OFFS;
              end
            end
          end
          ST_OFFS_ACK: begin
            if (scl_fall) begin
              s_next.sda_oe = 1'b0;
              s_next.st     = ST_WDATA;
            end
          end
          ST_WACK: begin
            // commit only once the ack slot has ended
            if (scl_fall) begin
              s_next.sda_oe = 1'b0;
              s_next.st     = ST_WDATA;
              s_next.off    = s_reg.off + 7'h01; // R14
              s_next.cksum  = s_reg.cksum + s_reg.sh; // R13
              if (s_reg.off == OFF_PAGE) begin
                s_next.page = s_reg.sh; // R18
              end else if (s_reg.page == PAGE_MAIN &&
                           s_reg.off == OFF_SWRST) begin
                if (s_reg.sh[BIT_SWRST]) begin
                  s_next = reg_defaults(s_next); // R03
                  s_next.local_addr = strap_addr(s_reg.strap_s1); // R08
                end
              end else if (s_reg.page == PAGE_MAIN &&
                           s_reg.off == OFF_BCAST) begin
                s_next.bcast_dis = ~s_reg.sh[BIT_BCAST]; // R11
              end else if (s_reg.page == PAGE_MAIN &&
                           s_reg.off == OFF_CKSUM) begin
                s_next.cksum = s_reg.sh;
              end else if (sl[2]) begin
                s_next.mem[sl[1:0]][s_reg.off] = s_reg.sh; // R01
              end
            end
          end
          ST_RDATA: begin
            if (scl_rise) begin
              s_next.cnt = s_reg.cnt + 4'h1;
            end else if (scl_fall) begin
              if (s_reg.cnt == BITS_PER_BYTE) begin
                s_next.sda_oe = 1'b0; // hand the ack slot to the host
                s_next.cnt    = 4'h0;
                s_next.st     = ST_RACK;
              end else if (s_reg.cnt != 4'h0) begin
                s_next.tx     = {s_reg.tx[6:0], 1'b0};
                s_next.sda_oe = ~s_reg.tx[6];
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              s_next.nack = s_reg.sda_s[1];
            end else if (scl_fall) begin
              if (!s_reg.nack) begin
                s_next.tx     = rd;
                s_next.sda_oe = ~rd[7];
                s_next.off    = s_reg.off + 7'h01; // R14
                s_next.st     = ST_RDATA;
              end else begin
                s_next.st = ST_IDLE; // R16
              end
            end
          end
          // unused codes fall back to idle rather than lock up
          default: begin
            s_next.st     = ST_IDLE;
            s_next.sda_oe = 1'b0;
          end
        endcase
      end
    end
  end

  // one register for all state; reset puts the target in shutdown
  always_ff @(posedge clk_i) begin
    if (!rst_n_i)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  // outputs straight from the state register
  assign sda_o        = s_reg.sda_lvl;
  assign sda_oe_o     = s_reg.sda_oe;
  assign cur_page_o   = s_reg.page;
  assign local_addr_o = s_reg.local_addr;

endmodule

// ===== pi2c_target_checker.sv
`timescale 1ns/1ps
module pi2c_target_checker (
  // clock, reset, pins
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic       shutdown_n_pin_i,
  input wire logic       addr_strap_low_i,
  input wire logic       addr_strap_high_i,
  // bus and status
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  input wire logic [7:0] cur_page_o,
  input wire logic [6:0] local_addr_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // straps held steady until the synchroniser has passed
  sequence s_release;
    $rose(shutdown_n_pin_i) ##1 (shutdown_n_pin_i &&
      $stable({addr_strap_high_i, addr_strap_low_i}))[*5];
  endsequence
  sequence s_ack_slot;
    $rose(sda_oe_o) ##[1:8] $rose(scl_i);
  endsequence
  a_strap_latch: assert property (s_release |-> local_addr_o ==
    {5'b10010, addr_strap_high_i, addr_strap_low_i})
    else $error("local address not latched from straps");
  a_addr_form: assert property (local_addr_o == 7'h00 ||
    local_addr_o[6:2] == 5'b10010) else $error("bad local address");
  a_reset_idle: assert property (disable iff (1'b0) !rst_n_i |=>
    cur_page_o == 8'h00 && !sda_oe_o) else $error("reset not idle");
  a_shut_idle: assert property (!shutdown_n_pin_i[*4] |=>
    cur_page_o == 8'h00 && !sda_oe_o) else $error("shutdown not idle");
  // data may only move while the clock is low
  a_oe_in_low: assert property ($changed(sda_oe_o) |->
    !$past(scl_i, 3)) else $error("sda drive moved in clock high");
  a_page_after_ack: assert property ($changed(cur_page_o) &&
    cur_page_o != 8'h00 |-> !$past(scl_i, 3))
    else $error("page changed outside clock low");
  a_drive_low: assert property (sda_oe_o |-> sda_o == 1'b0)
    else $error("open drain drives high");
  a_oe_stands: assert property (s_ack_slot |-> sda_oe_o[*4])
    else $error("sda drive dropped in clock high");
endmodule
bind pi2c_target pi2c_target_checker pi2c_target_checker_inst (
  .clk_i, .rst_n_i, .shutdown_n_pin_i, .addr_strap_low_i,
  .addr_strap_high_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .cur_page_o,
  .local_addr_o);

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
  import pi2c_pkg::*;
  logic       clk_i = 0;
  logic       rst_n_i = 0;
  logic       sdn = 0;
  logic       s_lo, s_hi, scl, hsda, sda_o, sda_oe_o, ak;
  logic [7:0] cur_page_o, q, me, r;
  logic [6:0] local_addr_o;
  wire        sda = hsda & ~sda_oe_o;
  int         fail_count = 0, compares = 0, pg, en, ck, off;
  int         m[384];
  initial forever #25 clk_i = ~clk_i;
  pi2c_target pi2c_target_inst (.clk_i, .rst_n_i,
    .shutdown_n_pin_i(sdn), .addr_strap_low_i(s_lo),
    .addr_strap_high_i(s_hi), .scl_i(scl), .sda_i(sda), .sda_o,
    .sda_oe_o, .cur_page_o, .local_addr_o);
  pi2c_host_model host_inst (.clk_i, .sda_i(sda), .scl_o(scl),
    .sda_o(hsda));
  // model storage base of a page, -1 when unbacked
  function automatic int slot(int p);
    return p == 0 ? 0 : p == 2 ? 128 : p == 3 ? 256 : -1;
  endfunction
  function automatic int expv();
    if (off == 0) return pg;
    if (pg == 0 && off < 4) return off == 1 ? 0 : off == 2 ? en : ck;
    return slot(pg) < 0 ? 0 : m[slot(pg) + off];
  endfunction
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic mreset();
    pg = 0;
    en = 1;
    ck = 0;
    m = '{default: 0};
  endtask
  // bytes after a refused address are still clocked out
  task automatic wr(logic [7:0] a, logic [7:0] o, logic [7:0] d[$]);
    logic hit;
    hit = a[7:1] == me[7:1] || (a == 8'h80 && en == 1);
    host_inst.start();
    host_inst.xbyte(a, 1'b1, q, ak);
    chk("addr_ack", {7'h0, ak}, {7'h0, !hit});
    host_inst.xbyte(o, 1'b1, q, ak);
    chk("offs_ack", {7'h0, ak}, {7'h0, !hit});
    if (hit) off = o[6:0];
    foreach (d[i]) begin
      host_inst.xbyte(d[i], 1'b1, q, ak);
      chk("data_ack", {7'h0, ak}, {7'h0, !hit});
      if (hit) begin
        if (!(pg == 0 && off == 3)) ck = (ck + d[i]) % 256;
        if (off == 0) pg = d[i];
        else if (pg == 0 && off == 1) begin
          if (d[i][0]) mreset();
        end
        else if (pg == 0 && off == 2) en = d[i][0];
        else if (pg == 0 && off == 3) ck = d[i];
        else if (slot(pg) >= 0) m[slot(pg) + off] = d[i];
        off = (off + 1) % 128;
      end
    end
    host_inst.stop();
  endtask
  task automatic rd(logic [7:0] o, int n);
    host_inst.start();
    host_inst.xbyte(me, 1'b1, q, ak);
    host_inst.xbyte(o, 1'b1, q, ak);
    off = o[6:0];
    host_inst.start();
    host_inst.xbyte(me | 8'h01, 1'b1, q, ak);
    for (int i = 0; i < n; i++) begin
      host_inst.xbyte(8'hff, i == n - 1, q, ak);
      chk("rdata", q, 8'(expv()));
      off = (off + 1) % 128;
    end
    host_inst.stop();
  endtask
  task automatic complete_run();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (100000) @(posedge clk_i);
    fail_count++;
    complete_run();
  end
  initial begin
    void'($urandom(42));
    {s_hi, s_lo} = 2'($urandom());
    mreset();
    repeat (20) @(negedge clk_i);
    rst_n_i = 1;
    repeat (4) @(negedge clk_i);
    sdn = 1;
    repeat (20) @(negedge clk_i);
    me = {5'b10010, s_hi, s_lo, 1'b0};
    chk("laddr", {1'b0, local_addr_o}, me >> 1);
    chk("page", cur_page_o, 8'h00);
    r = 8'($urandom());
    // offset msb ignored, wraps into the page register mid-burst
    wr(me, 8'hff, '{r, 8'h02, ~r});
    chk("page", cur_page_o, 8'h02);
    rd(8'h01, 1);
    wr(me, 8'h00, '{8'h00});
    rd(8'h7f, 2);
    for (int p = 3; p < 6; p += 2) begin
      wr(me, 8'h00, '{8'(p), 8'($urandom())});
      rd(8'h00, 2);
    end
    wr(me, 8'h00, '{8'h00});
    wr(8'ha0, 8'h10, '{8'h55});
    // shared address answers writes only, a read must go unacked
    host_inst.start();
    host_inst.xbyte(8'h81, 1'b1, q, ak);
    chk("gread_ack", {7'h0, ak}, 8'h01);
    host_inst.stop();
    wr(8'h80, 8'h20, '{r});
    rd(8'h20, 1);
    wr(me, 8'h02, '{8'h00});
    wr(8'h80, 8'h21, '{~r});
    // broadcast judged by its acks, then by the enable bit and checksum read back
    rd(8'h02, 2);
    wr(me, 8'h00, '{8'h02});
    // straps move while running: held until the soft reset relatches
    {s_hi, s_lo} = ~{s_hi, s_lo};
    repeat (8) @(negedge clk_i);
    chk("laddr", {1'b0, local_addr_o}, me >> 1);
    wr(me, 8'h00, '{8'h00, 8'h01});
    me = {5'b10010, s_hi, s_lo, 1'b0};
    chk("laddr", {1'b0, local_addr_o}, me >> 1);
    rd(8'h02, 1);
    sdn = 0;
    repeat (8) @(negedge clk_i);
    {s_hi, s_lo} = ~{s_hi, s_lo};
    sdn = 1;
    repeat (20) @(negedge clk_i);
    me = {5'b10010, s_hi, s_lo, 1'b0};
    chk("laddr", {1'b0, local_addr_o}, me >> 1);
    complete_run();
  end
endmodule
